// ---- design/dasbe_exec.sv ----
// Execution unit for decimal adjust, decrement-skip, interrupt gate, jump.
//
// What this block does
// - Decimal adjust turns binary sum into packed decimal, updates only carry.
// - Decrement addressed register 0..63; result to accumulator or register.
// - Zero decrement result discards the fetched next instruction as no-op.
// - Decrement-skip takes one cycle, or two when the skip happens.
// - Interrupt disable clears the global enable, blocking all requests.
// - Direct jump loads 9-bit immediate into program counter bits 8..0.
// - Direct jump loads program counter bit 9 from high buffer bit 1.
// - Interrupt enable sets the same global enable bit to one.
`timescale 1ns/1ps
module dasbe_exec (
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire dasbe_pkg::dasbe_instr_s       instr,
    input  wire logic                          instr_valid,
    input  wire logic [dasbe_pkg::DATA_W-1:0]  accumulator,
    input  wire logic                          carry_in,
    input  wire logic                          half_carry_in,
    input  wire logic [dasbe_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic [1:0]                    program_counter_high_buffer,
    output logic                               instr_ready,
    output dasbe_pkg::dasbe_wb_s               wb,
    output logic                               pc_load,
    output logic [dasbe_pkg::PC_W-1:0]         pc_target,
    output logic                               flush_fetch,
    output logic                               global_interrupt_enable
);
    // ************************************************************
    // Sequencer and registers
    // ************************************************************
    dasbe_pkg::dasbe_state_e             state_reg;
    dasbe_pkg::dasbe_state_e             state_next;
    dasbe_pkg::dasbe_wb_s                wb_reg;
    dasbe_pkg::dasbe_wb_s                wb_next;
    logic                                pc_load_reg;
    logic [dasbe_pkg::PC_W-1:0]          pc_target_reg;
    logic [dasbe_pkg::PC_W-1:0]          pc_target_next;
    logic                                int_en_reg;
    logic                                int_en_next;

    wire logic accept = instr_valid && (state_reg == dasbe_pkg::ST_RUN);
    wire logic is_adj = accept && (instr.op == dasbe_pkg::OP_DEC_ADJ);
    wire logic is_dsk = accept && (instr.op == dasbe_pkg::OP_DEC_SKIP);
    wire logic is_dis = accept && (instr.op == dasbe_pkg::OP_INT_DISABLE);
    wire logic is_ena = accept && (instr.op == dasbe_pkg::OP_INT_ENABLE);
    wire logic is_jmp = accept && (instr.op == dasbe_pkg::OP_DIRECT_JUMP);

    // ************************************************************
    // Datapath
    // ************************************************************
    // Decimal adjust: low nibble over nine or half carry adds six, high
    // part over 99 or carry adds sixty and sets carry. Carry is never
    // cleared, as a prior carry still means a hundreds digit.
    // decimal adjust
    wire logic adj_lo =
        (accumulator[dasbe_pkg::NIB_W-1:0] > dasbe_pkg::NIB_LIMIT)
        || half_carry_in;
    wire logic adj_hi = (accumulator > dasbe_pkg::HIGH_LIMIT) || carry_in;
    wire logic [dasbe_pkg::DATA_W-1:0] adj_val =
        accumulator + (adj_lo ? dasbe_pkg::ADJ_LOW : dasbe_pkg::DATA_ZERO)
                    + (adj_hi ? dasbe_pkg::ADJ_HIGH : dasbe_pkg::DATA_ZERO);

    wire logic [dasbe_pkg::DATA_W-1:0] dec_val =
        reg_rdata - dasbe_pkg::DATA_ONE;
    wire logic dec_zero = (dec_val == dasbe_pkg::DATA_ZERO);
    wire logic skip     = is_dsk && dec_zero;

    // Write-back selection.
    always_comb begin
        wb_next          = '0;
        wb_next.reg_addr = instr.reg_addr;
        if (is_adj) begin
            wb_next.acc_we   = 1'b1;
            wb_next.acc_data = adj_val;
            wb_next.carry_we = 1'b1;
            wb_next.carry    = adj_hi;
        end else if (is_dsk) begin
            wb_next.acc_we   = (instr.dest_sel == dasbe_pkg::DEST_ACC);
            wb_next.acc_data = dec_val;
            wb_next.reg_we   = (instr.dest_sel == dasbe_pkg::DEST_REG);
            wb_next.reg_data = dec_val;
        end
    end

    assign pc_target_next = {
        program_counter_high_buffer[dasbe_pkg::HIGH_BUF_BIT],
        instr.imm_addr};

    assign int_en_next = is_dis ? 1'b0 : (is_ena ? 1'b1 : int_en_reg);

    assign state_next = (skip || is_jmp) ? dasbe_pkg::ST_FLUSH
                                         : dasbe_pkg::ST_RUN;

    // Registered state and outputs; all return to quiet values at reset.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= dasbe_pkg::ST_RUN;
            wb_reg        <= '0;
            pc_load_reg   <= 1'b0;
            pc_target_reg <= '0;
            int_en_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            wb_reg        <= wb_next;
            pc_load_reg   <= is_jmp;
            pc_target_reg <= is_jmp ? pc_target_next : pc_target_reg;
            int_en_reg    <= int_en_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // The flush cycle executes a no-op: the fetched word is refused.
    // discard fetched
    assign instr_ready             = (state_reg == dasbe_pkg::ST_RUN);
    assign flush_fetch             = (state_reg == dasbe_pkg::ST_FLUSH);
    assign wb                      = wb_reg;
    assign pc_load                 = pc_load_reg;
    assign pc_target               = pc_target_reg;
    assign global_interrupt_enable = int_en_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    // A taken skip: decrement of a register that held one.
    sequence s_skip_taken;
        instr_valid && instr_ready
            && instr.op == dasbe_pkg::OP_DEC_SKIP && dec_zero;
    endsequence
    // A taken jump.
    sequence s_jump_taken;
        instr_valid && instr_ready && instr.op == dasbe_pkg::OP_DIRECT_JUMP;
    endsequence
    // The dead cycle: one refused word, then ready again.
    sequence s_dead_cycle;
        flush_fetch && !instr_ready ##1 instr_ready;
    endsequence

    AST_ADJ_CARRY: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        is_adj |=> wb.carry_we && wb.acc_we && !wb.reg_we
                   && wb.carry == $past(adj_hi))
        else $error("Decimal adjust write-back wrong.");
    AST_ADJ_KEEP_CARRY: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        is_adj && carry_in |=> wb.carry)
        else $error("Decimal adjust lost a prior carry.");
    AST_DEC_VALUE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        is_dsk |=> (wb.acc_we ? wb.acc_data : wb.reg_data)
                   == $past(reg_rdata) - dasbe_pkg::DATA_ONE
                   && (wb.reg_we == $past(instr.dest_sel)) && !wb.carry_we)
        else $error("Decrement result or destination wrong.");
    AST_DEC_ONE_DEST: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        is_dsk |=> wb.acc_we != wb.reg_we
                   && wb.reg_addr == $past(instr.reg_addr))
        else $error("Decrement destination not exactly one.");
    AST_SKIP_FLUSH: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_skip_taken |=> s_dead_cycle)
        else $error("Skip did not discard exactly one instruction.");
    AST_FLUSH_REFUSE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        flush_fetch |=> !wb.acc_we && !wb.reg_we && !wb.carry_we
                        && !pc_load && $stable(global_interrupt_enable))
        else $error("Refused word in dead cycle had an effect.");
    AST_NOSKIP_ONE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        is_dsk && !dec_zero |=> instr_ready)
        else $error("Non-skipping decrement took extra cycle.");
    AST_INT_EN_CLEAR: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        is_dis |=> !global_interrupt_enable)
        else $error("Interrupt disable did not clear enable.");
    AST_INT_EN_HOLD: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !global_interrupt_enable && !is_ena |=> !global_interrupt_enable)
        else $error("Global enable rose without an enable.");
    AST_JUMP_LOW: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_jump_taken |=> pc_load
            && pc_target[dasbe_pkg::IMM_W-1:0] == $past(instr.imm_addr))
        else $error("Jump low address wrong.");
    AST_PC_HOLD: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !pc_load |-> $stable(pc_target))
        else $error("Jump target moved without a load.");
    AST_JUMP_HIGH: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_jump_taken |=> pc_target[dasbe_pkg::PC_W-1]
            == $past(program_counter_high_buffer[dasbe_pkg::HIGH_BUF_BIT]))
        else $error("Jump bit nine wrong.");
    AST_INT_EN_SET: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        is_ena |=> global_interrupt_enable)
        else $error("Interrupt enable did not set enable.");
    AST_JUMP_TWO: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_jump_taken |=> s_dead_cycle)
        else $error("Jump did not take two cycles.");
    AST_PCLOAD_PULSE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        pc_load |=> !pc_load)
        else $error("Program counter load lasted over one cycle.");
    AST_DIS_ONE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        is_dis |=> instr_ready)
        else $error("Interrupt disable took extra cycle.");
endmodule

// ---- design/dasbe_pkg.sv ----
// Package of constants and types for the decimal adjust, skip and branch unit.
package dasbe_pkg;
    // ************************************************************
    // Operation codes presented by the decoder
    // ************************************************************
    typedef enum logic [2:0] {
        OP_NONE         = 3'b000,
        OP_DEC_ADJ      = 3'b001,
        OP_DEC_SKIP     = 3'b010,
        OP_INT_DISABLE  = 3'b011,
        OP_INT_ENABLE   = 3'b100,
        OP_DIRECT_JUMP  = 3'b101
    } dasbe_op_e;

    // ************************************************************
    // Execution sequencer states
    // ************************************************************
    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_FLUSH = 1'b1
    } dasbe_state_e;

    // ************************************************************
    // Widths, limits and constants
    // ************************************************************
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 6;
    localparam int          PC_W          = 10;
    localparam int          IMM_W         = 9;
    localparam int          NIB_W         = 4;
    localparam logic [7:0]  DATA_ZERO     = 8'h00;
    localparam logic [7:0]  DATA_ONE      = 8'h01;
    localparam logic [3:0]  NIB_LIMIT     = 4'h9;
    localparam logic [7:0]  ADJ_LOW       = 8'h06;
    localparam logic [7:0]  ADJ_HIGH      = 8'h60;
    localparam logic [7:0]  HIGH_LIMIT    = 8'h99;
    localparam int          HIGH_BUF_BIT  = 1;
    localparam logic        DEST_ACC      = 1'b0;
    localparam logic        DEST_REG      = 1'b1;

    // Instruction as presented by the decoder.
    typedef struct packed {
        dasbe_op_e               op;
        logic [ADDR_W-1:0]       reg_addr;
        logic                    dest_sel;
        logic [IMM_W-1:0]        imm_addr;
    } dasbe_instr_s;

    // Write-back produced by the unit.
    typedef struct packed {
        logic                    acc_we;
        logic [DATA_W-1:0]       acc_data;
        logic                    reg_we;
        logic [ADDR_W-1:0]       reg_addr;
        logic [DATA_W-1:0]       reg_data;
        logic                    carry_we;
        logic                    carry;
    } dasbe_wb_s;
endpackage

// ---- tb/dasbe_regfile_model.sv ----
// Behavioural data register file that faces the execution unit.
`timescale 1ns/1ps
module dasbe_regfile_model (
    input  wire logic                           ref_clk,
    input  wire logic                           rstn,
    input  wire logic [dasbe_pkg::ADDR_W-1:0]   rd_addr,
    input  wire dasbe_pkg::dasbe_wb_s           wb,
    output logic      [dasbe_pkg::DATA_W-1:0]   rd_data
);
    // ****************************************************
    // Storage
    // ****************************************************
    logic [7:0] mem_reg [64];

    // Reset seeds each register with its own address, so reads are easy
    // to predict; write-backs then prove the destination select.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 64; i++)
                mem_reg[i] <= 8'(i);
        end else if (wb.reg_we) begin
            mem_reg[wb.reg_addr] <= wb.reg_data;
        end
    end

    // Read is combinational, in the same cycle as the address.
    assign rd_data = mem_reg[rd_addr];
endmodule

// ---- tb/dasbe_exec_bench.sv ----
// Self-checking bench for the decimal adjust, skip and branch unit.
`timescale 1ns/1ps
module dasbe_exec_bench;
    // Row: op, addr, dest, imm, {hc,c,acc}, high buffer,
    // {cy,we[3],data}, {pc_load,target}, {gie,flush}.
    typedef struct {
        logic [2:0]  op;
        logic [5:0]  addr;
        logic        dest;
        logic [8:0]  imm;
        logic [9:0]  src;
        logic [1:0]  hb;
        logic [11:0] ex;
        logic [10:0] pc;
        logic [1:0]  gs;
    } dasbe_row_s;

    logic                      ref_clk;
    logic                      rstn;
    dasbe_pkg::dasbe_instr_s   instr;
    logic                      instr_valid;
    logic [7:0]                accumulator;
    logic                      carry_in;
    logic                      half_carry_in;
    logic [7:0]                reg_rdata;
    logic [1:0]                hb;
    logic                      instr_ready;
    dasbe_pkg::dasbe_wb_s      wb;
    logic                      pc_load;
    logic [9:0]                pc_target;
    logic                      flush_fetch;
    logic                      int_enable;
    int                        bad_count = 0;
    int                        cmp_count = 0;
    int                        cyc = 0;
    dasbe_row_s                rows [13] = '{
        '{3'h1, 6'h00, 1'b0, 9'h000, 10'h04D, 2'h0, 12'h553, 11'h000, 2'h0},
        '{3'h1, 6'h00, 1'b0, 9'h000, 10'h09A, 2'h0, 12'hD00, 11'h000, 2'h0},
        '{3'h1, 6'h00, 1'b0, 9'h000, 10'h322, 2'h0, 12'hD88, 11'h000, 2'h0},
        '{3'h2, 6'h05, 1'b0, 9'h000, 10'h000, 2'h0, 12'h404, 11'h000, 2'h0},
        '{3'h2, 6'h01, 1'b1, 9'h000, 10'h000, 2'h0, 12'h200, 11'h000, 2'h1},
        '{3'h2, 6'h3F, 1'b1, 9'h000, 10'h000, 2'h0, 12'h23E, 11'h000, 2'h0},
        '{3'h2, 6'h00, 1'b0, 9'h000, 10'h000, 2'h0, 12'h4FF, 11'h000, 2'h0},
        '{3'h2, 6'h01, 1'b0, 9'h000, 10'h000, 2'h0, 12'h4FF, 11'h000, 2'h0},
        '{3'h4, 6'h00, 1'b0, 9'h000, 10'h000, 2'h0, 12'h000, 11'h000, 2'h2},
        '{3'h5, 6'h00, 1'b0, 9'h1FF, 10'h000, 2'h2, 12'h000, 11'h7FF, 2'h3},
        '{3'h3, 6'h00, 1'b0, 9'h000, 10'h000, 2'h0, 12'h000, 11'h000, 2'h0},
        '{3'h5, 6'h00, 1'b0, 9'h0A5, 10'h000, 2'h1, 12'h000, 11'h4A5, 2'h1},
        '{3'h0, 6'h05, 1'b1, 9'h000, 10'h000, 2'h0, 12'h000, 11'h000, 2'h0}};

    dasbe_exec dut (.ref_clk(ref_clk), .rstn(rstn), .instr(instr),
        .instr_valid(instr_valid), .accumulator(accumulator),
        .carry_in(carry_in), .half_carry_in(half_carry_in),
        .reg_rdata(reg_rdata), .program_counter_high_buffer(hb),
        .instr_ready(instr_ready), .wb(wb), .pc_load(pc_load),
        .pc_target(pc_target), .flush_fetch(flush_fetch),
        .global_interrupt_enable(int_enable));
    dasbe_regfile_model far_side (.ref_clk(ref_clk), .rstn(rstn),
        .rd_addr(instr.reg_addr), .wb(wb), .rd_data(reg_rdata));

    // ****************************************************
    // Compare and closing tasks
    // ****************************************************
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One instruction per call; the idle edge after it covers any flush.
    task automatic run_row(input dasbe_row_s r);
        @(posedge ref_clk);
        instr <= '{dasbe_pkg::dasbe_op_e'(r.op), r.addr, r.dest, r.imm};
        {half_carry_in, carry_in, accumulator} <= r.src;
        hb <= r.hb;
        instr_valid <= 1'b1;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
        cmp_val(10'({wb.acc_we, wb.reg_we, wb.carry_we}), 10'(r.ex[10:8]));
        if (r.ex[10]) cmp_val(10'(wb.acc_data), 10'(r.ex[7:0]));
        if (r.ex[9]) cmp_val(10'(wb.reg_data), 10'(r.ex[7:0]));
        if (r.ex[9]) cmp_val(10'(wb.reg_addr), 10'(r.addr));
        if (r.ex[8]) cmp_flag(wb.carry, r.ex[11]);
        cmp_flag(pc_load, r.pc[10]);
        if (r.pc[10]) cmp_val(pc_target, r.pc[9:0]);
        cmp_flag(int_enable, r.gs[1]);
        cmp_flag(instr_ready, !r.gs[0]);
        cmp_flag(flush_fetch, r.gs[0]);
    endtask

    // Free-running 200 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // A hang ends the run as a failure long after the tests should finish.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // Main sequence: table first, then flush refusal and mid-run reset.
    initial begin
        rstn = 1'b0;
        instr = '0;
        instr_valid = 1'b0;
        {half_carry_in, carry_in, accumulator} = 10'h000;
        hb = 2'h0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        // flush refusal: enable held in the dead cycle is ignored.
        @(posedge ref_clk);
        instr <= '{dasbe_pkg::OP_DIRECT_JUMP, 6'h00, 1'b0, 9'h012};
        instr_valid <= 1'b1;
        @(posedge ref_clk);
        instr.op <= dasbe_pkg::OP_INT_ENABLE;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
        cmp_flag(int_enable, 1'b0);
        cmp_val(pc_target, 10'h012);
        run_row(rows[8]);
        // mid-run reset clears the global enable again.
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(negedge ref_clk);
        cmp_flag(int_enable, 1'b0);
        cmp_flag(instr_ready, 1'b1);
        // Release again; outputs stay quiet and the first word is taken.
        @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        cmp_flag(pc_load, 1'b0);
        cmp_val(pc_target, 10'h000);
        cmp_flag(flush_fetch, 1'b0);
        run_row(rows[4]);
        report_and_stop();
    end
endmodule
